// ### adsq_pkg_sync.sv
/*
 Shared constants and carrier types for the converter control sequencer,
 plus the two-flop level synchroniser used for the chip-select and toggle crossings.
 Assumes the including design compiles this file first.
*/

package adsq_pkg;
   // ****************************************************************
   // Serial word layout
   // ****************************************************************
   localparam logic [3:0] CMD_SETUP = 4'h000F;
   localparam int WORD_BITS = 8;
   localparam logic [3:0] LAST_IN_BIT = 4'h0007;

   // ****************************************************************
   // Transfer lengths
   // ****************************************************************
   localparam logic [1:0] LEN_CODE_8 = 2'h1;
   localparam logic [1:0] LEN_CODE_12 = 2'h0;
   localparam logic [1:0] LEN_CODE_16 = 2'h3;
   localparam logic [4:0] LEN_8 = 5'h08;
   localparam logic [4:0] LEN_12 = 5'h0C;
   localparam logic [4:0] LEN_16 = 5'h10;

   // ****************************************************************
   // Reset and default-mode values
   // ****************************************************************
   localparam logic [3:0] SETUP_RST = 4'h0000;
   localparam logic [3:0] FORMAT_RST = 4'h0000;
   localparam logic [1:0] REF_EXTERNAL = 2'h0;
   localparam logic [3:0] CHAN_ZERO = 4'h0000;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int MCLK_PERIOD_NS = 100;
   localparam int CS_SETUP_NS = 33;
   // Least time: round up, never below one cycle
   localparam int CS_SETUP_CYC_RAW =
      (CS_SETUP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam logic [3:0] CS_SETUP_CYC =
      4'(CS_SETUP_CYC_RAW < 1 ? 1 : CS_SETUP_CYC_RAW);

   typedef struct packed {
      logic [3:0] cmd;
      logic [3:0] data;
   } adsq_word_t;

   typedef struct packed {
      logic [1:0] ref_sel;
      logic int_mode;
      logic dflt;
   } adsq_setup_t;

   typedef struct packed {
      logic [1:0] len;
      logic lsb_first;
      logic bipolar;
   } adsq_format_t;
endpackage : adsq_pkg

`timescale 1ns/1ns

module adsq_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_d,
   output logic [WIDTH-1:0] o_q
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] q_reg;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_reg <= RST_VAL;
         q_reg <= RST_VAL;
      end else begin
         meta_reg <= i_d;
         q_reg <= meta_reg;
      end
   end

   assign o_q = q_reg;
endmodule : adsq_sync

// ### adsq_top.sv
/*
 Start-up and configuration sequencer for a serial SAR converter port.
 Link logic runs on the host shift clock; sequencing runs on I_MCLK.
 Assumes the host keeps its own rules and the converter pulses
 I_CONV_DONE on I_MCLK when a conversion finishes.
*/

`timescale 1ns/1ns

module adsq_top (
   input wire logic I_MCLK,
   input wire logic I_RST,
   input wire logic I_IOCLK,
   input wire logic I_CS_N,
   input wire logic I_DIN,
   input wire logic I_CONV_DONE,
   output adsq_pkg::adsq_setup_t O_SETUP,
   output adsq_pkg::adsq_format_t O_FORMAT,
   output logic [3:0] O_CHANNEL,
   output logic O_CONV_START,
   output logic O_CONV_VALID,
   output logic O_OUT_VALID,
   output logic O_STATUS
);
   import adsq_pkg::*;

   // ****************************************************************
   // Link domain: shift-in and cycle framing
   // ****************************************************************
   // Frame state is cleared whenever chip select is high
   logic frame_rst;
   logic [3:0] bit_cnt_reg, bit_cnt_next;
   logic [6:0] sh_reg, sh_next;
   adsq_word_t word_reg, word_next;
   logic tog_reg, tog_next;
   logic [1:0] lk_len_reg, lk_len_next;
   logic lk_dflt_reg, lk_dflt_next;
   logic [4:0] cyc_len;
   logic cyc_end;

   assign frame_rst = I_RST | I_CS_N;

   function automatic logic [4:0] len_decode(input logic [1:0] code);
      logic [4:0] n;
      n = LEN_12;
      if (code == LEN_CODE_8) n = LEN_8;
      else if (code == LEN_CODE_16) n = LEN_16;
      return n;
   endfunction : len_decode

   always_comb begin
      adsq_word_t full;
      full = {sh_reg, I_DIN};
      sh_next = sh_reg;
      word_next = word_reg;
      lk_len_next = lk_len_reg;
      lk_dflt_next = lk_dflt_reg;
      // Data input ignored past the eighth edge
      if (bit_cnt_reg < LAST_IN_BIT) begin
         sh_next = {sh_reg[5:0], I_DIN};
      end
      if (bit_cnt_reg == LAST_IN_BIT) begin
         word_next = full;
         if (full.cmd == CMD_SETUP) begin
            lk_dflt_next = full.data[0];
         end else begin
            lk_len_next = full.data[3:2];
         end
      end
      cyc_len = lk_dflt_next ? LEN_16 : len_decode(lk_len_next);
      cyc_end = ({1'b0, bit_cnt_reg} + 5'h01) == cyc_len;
      if (cyc_end) begin
         bit_cnt_next = 4'h0000;
         tog_next = ~tog_reg;
      end else begin
         bit_cnt_next = bit_cnt_reg + 4'h0001;
         tog_next = tog_reg;
      end
   end

   always_ff @(posedge I_IOCLK or posedge frame_rst) begin
      if (frame_rst) begin
         bit_cnt_reg <= 4'h0000;
         sh_reg <= 7'h00;
      end else begin
         bit_cnt_reg <= bit_cnt_next;
         sh_reg <= sh_next;
      end
   end

   // Word and toggle survive chip select so the crossing stays intact
   always_ff @(posedge I_IOCLK or posedge I_RST) begin
      if (I_RST) begin
         word_reg <= '0;
         tog_reg <= 1'b0;
         lk_len_reg <= FORMAT_RST[3:2];
         lk_dflt_reg <= SETUP_RST[0];
      end else begin
         word_reg <= word_next;
         tog_reg <= tog_next;
         lk_len_reg <= lk_len_next;
         lk_dflt_reg <= lk_dflt_next;
      end
   end

   // ****************************************************************
   // Crossings into the I_MCLK domain
   // ****************************************************************
   logic cs_n_s, tog_s;

   adsq_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_cs_sync (
      .i_clk(I_MCLK),
      .i_rst(I_RST),
      .i_d(I_CS_N),
      .o_q(cs_n_s)
   );

   adsq_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_tog_sync (
      .i_clk(I_MCLK),
      .i_rst(I_RST),
      .i_d(tog_reg),
      .o_q(tog_s)
   );

   // ****************************************************************
   // Sequencing domain
   // ****************************************************************
   logic tog_d_reg, tog_d_next;
   logic [3:0] cs_cnt_reg, cs_cnt_next;
   adsq_setup_t setup_reg, setup_next;
   adsq_format_t fmt_reg, fmt_next;
   adsq_setup_t eff_setup_reg, eff_setup_next;
   adsq_format_t eff_fmt_reg, eff_fmt_next;
   logic [3:0] chan_reg, chan_next;
   logic setup_done_reg, setup_done_next;
   logic start_reg, start_next;
   logic valid_reg, valid_next;
   logic out_valid_reg, out_valid_next;
   logic status_reg, status_next;
   logic [1:0] cyc_cnt_reg, cyc_cnt_next;
   logic armed, arrive, accepted;
   adsq_word_t w;

   assign armed = (cs_cnt_reg == CS_SETUP_CYC);
   assign arrive = tog_s ^ tog_d_reg;
   // Word held stable for many link edges once the toggle lands
   assign w = word_reg;
   assign accepted = arrive & armed;

   always_comb begin
      tog_d_next = tog_s;
      cs_cnt_next = cs_cnt_reg;
      if (cs_n_s) cs_cnt_next = 4'h0000;
      else if (!armed) cs_cnt_next = cs_cnt_reg + 4'h0001;
      setup_next = setup_reg;
      fmt_next = fmt_reg;
      chan_next = chan_reg;
      setup_done_next = setup_done_reg;
      start_next = 1'b0;
      valid_next = valid_reg;
      out_valid_next = out_valid_reg;
      status_next = status_reg;
      cyc_cnt_next = cyc_cnt_reg;
      if (accepted) begin
         start_next = 1'b1;
         if (cyc_cnt_reg != 2'h3) cyc_cnt_next = cyc_cnt_reg + 2'h1;
         if (w.cmd == CMD_SETUP) begin
            setup_next = w.data;
            setup_done_next = 1'b1;
            valid_next = 1'b0;
         end else begin
            fmt_next = w.data;
            chan_next = w.cmd;
            valid_next = setup_done_reg;
         end
         // Result shifted next cycle is only as good as this one
         out_valid_next = valid_next;
         // EOC falls at start; INT is released by the new cycle
         // Effective mode, so default mode always signals EOC
         status_next = eff_setup_reg.int_mode ? 1'b1 : 1'b0;
      end else if (I_CONV_DONE) begin
         status_next = eff_setup_reg.int_mode ? 1'b0 : 1'b1;
      end
      eff_setup_next = setup_next;
      eff_fmt_next = fmt_next;
      if (setup_next.dflt) begin
         eff_setup_next.ref_sel = REF_EXTERNAL;
         eff_setup_next.int_mode = 1'b0;
         eff_fmt_next.len = LEN_CODE_16;
         eff_fmt_next.lsb_first = 1'b0;
      end
      if (setup_next.dflt && accepted) chan_next = CHAN_ZERO;
   end

   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         tog_d_reg <= 1'b0;
         cs_cnt_reg <= 4'h0000;
         setup_reg <= SETUP_RST;
         fmt_reg <= FORMAT_RST;
         eff_setup_reg <= SETUP_RST;
         eff_fmt_reg <= FORMAT_RST;
         chan_reg <= CHAN_ZERO;
         setup_done_reg <= 1'b0;
         start_reg <= 1'b0;
         valid_reg <= 1'b0;
         out_valid_reg <= 1'b0;
         status_reg <= 1'b1;
         cyc_cnt_reg <= 2'h0;
      end else begin
         tog_d_reg <= tog_d_next;
         cs_cnt_reg <= cs_cnt_next;
         setup_reg <= setup_next;
         fmt_reg <= fmt_next;
         eff_setup_reg <= eff_setup_next;
         eff_fmt_reg <= eff_fmt_next;
         chan_reg <= chan_next;
         setup_done_reg <= setup_done_next;
         start_reg <= start_next;
         valid_reg <= valid_next;
         out_valid_reg <= out_valid_next;
         status_reg <= status_next;
         cyc_cnt_reg <= cyc_cnt_next;
      end
   end

   assign O_SETUP = eff_setup_reg;
   assign O_FORMAT = eff_fmt_reg;
   assign O_CHANNEL = chan_reg;
   assign O_CONV_START = start_reg;
   assign O_CONV_VALID = valid_reg;
   assign O_OUT_VALID = out_valid_reg;
   assign O_STATUS = status_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   chk_setup_guard: assert property (@(posedge I_MCLK) disable iff (I_RST)
      accepted && w.cmd != CMD_SETUP |=> $stable(setup_reg))
      else $error("setup register changed on a non-setup command");

   chk_setup_load: assert property (@(posedge I_MCLK) disable iff (I_RST)
      accepted && w.cmd == CMD_SETUP |=> setup_reg == $past(w.data))
      else $error("setup register not loaded from command 1111");

   chk_format_load: assert property (@(posedge I_MCLK) disable iff (I_RST)
      accepted && w.cmd != CMD_SETUP |=> fmt_reg == $past(w.data)
         && O_CONV_START)
      else $error("format register not loaded with conversion start");

   chk_valid_after: assert property (@(posedge I_MCLK) disable iff (I_RST)
      accepted && w.cmd != CMD_SETUP && setup_done_reg
         |=> O_CONV_VALID ##1 O_CONV_VALID)
      else $error("cycle after setup write not valid");

   chk_no_early: assert property (@(posedge I_MCLK) disable iff (I_RST)
      accepted && !setup_done_reg |=> !O_CONV_VALID && !O_OUT_VALID)
      else $error("conversion flagged valid before setup");

   chk_third_cycle: assert property (@(posedge I_MCLK) disable iff (I_RST)
      O_OUT_VALID |-> cyc_cnt_reg >= 2'h2)
      else $error("output valid before third cycle");

   chk_default_fmt: assert property (@(posedge I_MCLK) disable iff (I_RST)
      setup_reg.dflt |-> O_FORMAT.len == LEN_CODE_16 && !O_FORMAT.lsb_first
         && O_SETUP.ref_sel == REF_EXTERNAL && !O_SETUP.int_mode)
      else $error("default mode settings not forced");

   chk_cs_setup: assert property (@(posedge I_MCLK) disable iff (I_RST)
      arrive && !armed |=> $stable(fmt_reg) && $stable(setup_reg)
         && !O_CONV_START)
      else $error("activity acted on inside chip-select setup");

   chk_cycle_wrap: assert property (@(posedge I_IOCLK) disable iff (frame_rst)
      bit_cnt_reg == 4'h000F |=> bit_cnt_reg == 4'h0000)
      else $error("link cycle ran past sixteen clocks");

   chk_status_eoc: assert property (@(posedge I_MCLK) disable iff (I_RST)
      accepted && !eff_setup_reg.int_mode |=> !O_STATUS)
      else $error("status pin did not fall at conversion start");
endmodule : adsq_top

// ### adsq_host.sv
/*
 Host model for the converter control sequencer: drives chip select,
 the shift clock and the serial command input, one frame per call.
 Assumes the caller spaces frames far enough for the sequencer.
*/
`timescale 1ns/1ns

module adsq_host (
   output logic o_ioclk,
   output logic o_cs_n,
   output logic o_din
);
   // ****************************************************************
   // Frame driver
   // ****************************************************************
   initial begin
      o_ioclk = 1'b0;
      o_din = 1'b0;
      // Brief low at start gives the frame reset a real rising edge
      o_cs_n = 1'b0;
      #10 o_cs_n = 1'b1;
   end

   // Shift clock stands still outside frames; 48 ns period inside
   task automatic xfer(input logic [7:0] w, input logic [4:0] n,
                       input logic keep);
      if (o_cs_n === 1'b1) begin
         o_cs_n = 1'b0;
         #100;
      end
      for (int i = 0; i < n; i++) begin
         // Past bit eight the line toggles, nothing to capture
         o_din = (i < 8) ? w[7 - i] : ~o_din;
         #24 o_ioclk = 1'b1;
         #24 o_ioclk = 1'b0;
      end
      if (!keep) begin
         #100 o_cs_n = 1'b1;
         o_din = ~o_din;
         #100;
      end
   endtask : xfer
endmodule : adsq_host

// ### tb_adsq_top.sv
/*
 Self-checking bench for the converter control sequencer: a table of
 host frames with the outputs each accepted cycle must show.
 Assumes adsq_pkg and adsq_host are compiled first.
*/
`timescale 1ns/1ns

module tb_adsq_top;
   import adsq_pkg::*;
   typedef struct packed {
      logic [7:0] w;
      logic [4:0] n;
      logic keep;
      logic [3:0] su;
      logic [3:0] fm;
      logic [3:0] ch;
      logic vl;
   } adsq_step_t;
   // Setup writes first; setup frames keep the last format write's length,
   // sixteen when the write enters default mode
   localparam adsq_step_t STEPS [10] = '{
      '{8'hF3, 5'h10, 1'b0, 4'h1, 4'h0, 4'h0, 1'b0},
      '{8'h52, 5'h10, 1'b0, 4'h1, 4'hC, 4'h0, 1'b1},
      '{8'hF6, 5'h0C, 1'b0, 4'h6, 4'h0, 4'h0, 1'b0},
      '{8'h34, 5'h08, 1'b1, 4'h6, 4'h4, 4'h3, 1'b1},
      '{8'h20, 5'h0C, 1'b1, 4'h6, 4'h0, 4'h2, 1'b1},
      '{8'h1C, 5'h10, 1'b1, 4'h6, 4'hC, 4'h1, 1'b1},
      '{8'hF6, 5'h10, 1'b0, 4'h6, 4'h0, 4'h0, 1'b0},
      '{8'h75, 5'h08, 1'b0, 4'h6, 4'h5, 4'h7, 1'b1},
      '{8'hF6, 5'h08, 1'b0, 4'h6, 4'h0, 4'h0, 1'b0},
      '{8'h90, 5'h0C, 1'b1, 4'h6, 4'h0, 4'h9, 1'b1}};
   logic mclk = 1'b0;
   logic rst = 1'b0;
   logic conv_done = 1'b0;
   logic ioclk, cs_n, din, conv_start, conv_valid, out_valid, status;
   adsq_setup_t setup;
   adsq_format_t format;
   logic [3:0] channel;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int k;

   adsq_host host (.o_ioclk(ioclk), .o_cs_n(cs_n), .o_din(din));
   adsq_top dut (.I_MCLK(mclk), .I_RST(rst), .I_IOCLK(ioclk),
      .I_CS_N(cs_n), .I_DIN(din), .I_CONV_DONE(conv_done),
      .O_SETUP(setup), .O_FORMAT(format), .O_CHANNEL(channel),
      .O_CONV_START(conv_start), .O_CONV_VALID(conv_valid),
      .O_OUT_VALID(out_valid), .O_STATUS(status));

   // ****************************************************************
   // Clock, timeout and reporting
   // ****************************************************************
   initial begin
      forever #50 mclk = ~mclk;
   end

   // About 160 cycles expected; generous ceiling
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 8000) begin
         err_count++;
         summarize();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize();
      if (err_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize

   // ****************************************************************
   // Sequence
   // ****************************************************************
   initial begin
      // Raised on an edge so the link flops see a real reset edge
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      check({4'h0, setup}, 8'h00);
      check({4'h0, format}, 8'h00);
      check({7'h00, status}, 8'h01);
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      foreach (STEPS[s]) begin
         host.xfer(STEPS[s].w, STEPS[s].n, STEPS[s].keep);
         k = 0;
         while (conv_start !== 1'b1 && k < 60) begin
            @(posedge mclk);
            #1;
            k++;
         end
         check({7'h00, conv_start}, 8'h01);
         check({4'h0, setup}, {4'h0, STEPS[s].su});
         check({7'h00, conv_valid}, {7'h00, STEPS[s].vl});
         if (s < 2) begin
            check({7'h00, out_valid}, 8'(s));
         end
         if (STEPS[s].w[7:4] != CMD_SETUP) begin
            check({4'h0, format}, {4'h0, STEPS[s].fm});
            check({4'h0, channel}, {4'h0, STEPS[s].ch});
            check({7'h00, status}, {7'h00, STEPS[s].su[1]});
            @(posedge mclk);
            conv_done <= 1'b1;
            @(posedge mclk);
            conv_done <= 1'b0;
            @(posedge mclk);
            #1;
            check({7'h00, status}, {7'h00, ~STEPS[s].su[1]});
         end
      end
      // Frame cut short by chip select: no cycle, nothing changes
      host.xfer(8'h3C, 5'h04, 1'b0);
      k = 0;
      repeat (30) begin
         @(posedge mclk);
         #1;
         if (conv_start !== 1'b0) begin
            k++;
         end
      end
      check(8'(k), 8'h00);
      check({4'h0, channel}, 8'h09);
      summarize();
   end
endmodule : tb_adsq_top
